// >>> current_dac_update_control.sv
// update control for the 10-bit current output dac
module current_dac_update_control
   import dac_update_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_write,
   input wire logic sfr_read,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic [3:0] timer_overflow,
   input wire logic convert_start_pin,
   output logic [9:0] dac_latch,
   output logic dac_latch_update,
   output logic dac_enable,
   output logic [1:0] full_scale_select,
   output full_scale_t full_scale_mode,
   output logic pin_digital_disable,
   output logic pin_analog_connect
);
   // =====================================
   // registers
   logic dac_enable_reg;
   logic [2:0] update_source_select_reg;
   logic [1:0] full_scale_select_reg;
   logic [7:0] word_upper_bits_reg;
   logic [1:0] word_lower_bits_reg;
   logic [9:0] dac_latch_reg;
   logic update_pulse_reg;
   logic write_high;
   logic write_low;
   logic write_ctrl;
   logic update_event;
   logic [7:0] control_view;
   pin_edge_if edges ();

   pin_edge_detect u_edge (
      .clk(clk),
      .srst(srst),
      .convert_start_pin(convert_start_pin),
      .edges(edges)
   );

   assign write_high = sfr_write && (sfr_addr == DAC_HIGH_OFFSET);
   assign write_low = sfr_write && (sfr_addr == DAC_LOW_OFFSET);
   assign write_ctrl = sfr_write && (sfr_addr == DAC_CONTROL_OFFSET);

   always_ff @(posedge clk) begin
      if (srst) begin
         dac_enable_reg <= DAC_CONTROL_RESET[ENABLE_BIT];
         update_source_select_reg <= DAC_CONTROL_RESET[SOURCE_MSB:SOURCE_LSB];
         full_scale_select_reg <= DAC_CONTROL_RESET[SCALE_MSB:SCALE_LSB];
      end else if (write_ctrl) begin
         dac_enable_reg <= sfr_wdata[ENABLE_BIT];
         update_source_select_reg <= sfr_wdata[SOURCE_MSB:SOURCE_LSB];
         full_scale_select_reg <= sfr_wdata[SCALE_MSB:SCALE_LSB];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         word_upper_bits_reg <= DAC_HIGH_RESET;
      end else if (write_high) begin
         word_upper_bits_reg <= sfr_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         word_lower_bits_reg <= DAC_LOW_RESET;
      end else if (write_low) begin
         word_lower_bits_reg <= sfr_wdata[LOW_DATA_MSB:LOW_DATA_LSB];
      end
   end

   // =====================================
   // update event selection
   always_comb begin
      update_event = 1'b0;
      case (update_source_select_reg)
         3'h0, 3'h1, 3'h2, SRC_TIMER3: begin
            update_event = timer_overflow[update_source_select_reg[1:0]];
         end
         SRC_PIN_RISE: begin
            update_event = edges.rise;
         end
         SRC_PIN_FALL: begin
            update_event = edges.fall;
         end
         SRC_PIN_ANY: begin
            update_event = edges.rise | edges.fall;
         end
         SRC_HIGH_WRITE: begin
            update_event = write_high;
         end
         default: begin
            update_event = 1'b0;
         end
      endcase
   end

   // high byte write in mode 111 latches the new high byte with held low bits
   always_ff @(posedge clk) begin
      if (srst) begin
         dac_latch_reg <= {DAC_HIGH_RESET, DAC_LOW_RESET};
      end else if (update_event) begin
         if (update_source_select_reg == SRC_HIGH_WRITE) begin
            dac_latch_reg <= {sfr_wdata, word_lower_bits_reg};
         end else begin
            dac_latch_reg <= {word_upper_bits_reg, word_lower_bits_reg};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         update_pulse_reg <= 1'b0;
      end else begin
         update_pulse_reg <= update_event;
      end
   end

   // =====================================
   // read path
   assign control_view = {dac_enable_reg, update_source_select_reg, 2'h0,
                          full_scale_select_reg};

   always_comb begin
      sfr_rdata = 8'h00;
      sfr_hit = 1'b0;
      if (sfr_read) begin
         case (sfr_addr)
            DAC_HIGH_OFFSET: begin
               sfr_rdata = word_upper_bits_reg;
               sfr_hit = 1'b1;
            end
            DAC_LOW_OFFSET: begin
               sfr_rdata = {word_lower_bits_reg, 6'h00};
               sfr_hit = 1'b1;
            end
            DAC_CONTROL_OFFSET: begin
               sfr_rdata = control_view;
               sfr_hit = 1'b1;
            end
            default: begin
               sfr_rdata = 8'h00;
            end
         endcase
      end
   end

   // =====================================
   // analog side controls
   always_comb begin
      case (full_scale_select_reg)
         SCALE_HALF_MA: full_scale_mode = SCALE_0P5;
         SCALE_ONE_MA: full_scale_mode = SCALE_1P0;
         default: full_scale_mode = SCALE_2P0;
      endcase
   end

   assign dac_latch = dac_latch_reg;
   assign dac_latch_update = update_pulse_reg;
   assign dac_enable = dac_enable_reg;
   assign full_scale_select = full_scale_select_reg;
   assign pin_digital_disable = dac_enable_reg;
   assign pin_analog_connect = dac_enable_reg;
endmodule

// >>> dac_update_pkg.sv
// constants for the current dac update control block
package dac_update_pkg;
   localparam logic [7:0] DAC_LOW_OFFSET = 8'h96;
   localparam logic [7:0] DAC_HIGH_OFFSET = 8'h97;
   localparam logic [7:0] DAC_CONTROL_OFFSET = 8'hB9;
   localparam logic [7:0] DAC_CONTROL_RESET = 8'h72;
   localparam logic [7:0] DAC_HIGH_RESET = 8'h00;
   localparam logic [1:0] DAC_LOW_RESET = 2'h0;
   localparam int ENABLE_BIT = 7;
   localparam int SOURCE_MSB = 6;
   localparam int SOURCE_LSB = 4;
   localparam int SCALE_MSB = 1;
   localparam int SCALE_LSB = 0;
   localparam int LOW_DATA_MSB = 7;
   localparam int LOW_DATA_LSB = 6;
   localparam logic [2:0] SRC_TIMER0 = 3'h0;
   localparam logic [2:0] SRC_TIMER3 = 3'h3;
   localparam logic [2:0] SRC_PIN_RISE = 3'h4;
   localparam logic [2:0] SRC_PIN_FALL = 3'h5;
   localparam logic [2:0] SRC_PIN_ANY = 3'h6;
   localparam logic [2:0] SRC_HIGH_WRITE = 3'h7;
   localparam logic [1:0] SCALE_HALF_MA = 2'h0;
   localparam logic [1:0] SCALE_ONE_MA = 2'h1;
   localparam logic [1:0] SCALE_TWO_MA = 2'h2;
   typedef enum logic [1:0] {SCALE_0P5, SCALE_1P0, SCALE_2P0} full_scale_t;
endpackage

// >>> pin_edge_if.sv
// carrier between the pin edge detector and the control core
interface pin_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport detector (output level, output rise, output fall);
   modport core (input level, input rise, input fall);
endinterface

// >>> pin_edge_detect.sv
// two-flop synchroniser and edge detector for the convert start pin
module pin_edge_detect (
   input wire logic clk,
   input wire logic srst,
   input wire logic convert_start_pin,
   pin_edge_if.detector edges
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // first flop only feeds the second
   always_ff @(posedge clk) begin
      if (srst) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end else begin
         meta_reg <= convert_start_pin;
         sync_reg <= meta_reg;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         last_reg <= 1'b0;
      end else begin
         last_reg <= sync_reg;
      end
   end

   assign edges.level = sync_reg;
   assign edges.rise = sync_reg & ~last_reg;
   assign edges.fall = ~sync_reg & last_reg;
endmodule

// >>> current_dac_update_control_sva.sv
// checker for the current dac update control block
module current_dac_update_control_sva
   import dac_update_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_write,
   input wire logic sfr_read,
   input wire logic [7:0] sfr_rdata,
   input wire logic [3:0] timer_overflow,
   input wire logic [9:0] dac_latch,
   input wire logic dac_latch_update,
   input wire logic dac_enable,
   input wire logic [1:0] full_scale_select,
   input wire full_scale_t full_scale_mode,
   input wire logic pin_digital_disable,
   input wire logic pin_analog_connect
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // ==========
   // shadow of the update source field
   logic [2:0] src_reg;
   always_ff @(posedge clk) begin
      if (srst) src_reg <= SRC_HIGH_WRITE;
      else if (sfr_write && sfr_addr == DAC_CONTROL_OFFSET) src_reg <= sfr_wdata[6:4];
   end
   // ==========
   // properties
   chk_low_pad_zero: assert property (sfr_read && sfr_addr == 8'h96 |-> sfr_rdata[5:0] == 6'h00)
      else $error("low byte pad bits not zero");
   chk_ctl_pad_zero: assert property (sfr_read && sfr_addr == 8'hB9 |-> sfr_rdata[3:2] == 2'h0)
      else $error("control bits 3:2 not zero");
   chk_pin_follow: assert property (pin_digital_disable == dac_enable && pin_analog_connect == dac_enable)
      else $error("pin mode does not follow enable");
   chk_scale_decode: assert property (full_scale_mode == (full_scale_select[1] ? SCALE_2P0 :
      (full_scale_select[0] ? SCALE_1P0 : SCALE_0P5)))
      else $error("full scale decode wrong");
   chk_write_latch: assert property (sfr_write && sfr_addr == 8'h97 && src_reg == 3'h7 |=>
      dac_latch_update && dac_latch[9:2] == $past(sfr_wdata))
      else $error("high byte write did not latch");
   chk_timer_latch: assert property (!src_reg[2] && timer_overflow[src_reg[1:0]] |=> dac_latch_update)
      else $error("timer overflow did not latch");
   chk_timer_hold: assert property (!src_reg[2] && !timer_overflow[src_reg[1:0]] |=> $stable(dac_latch))
      else $error("latch moved without event");
   chk_high_readback: assert property (sfr_write && sfr_addr == 8'h97 ##1 sfr_read && sfr_addr == 8'h97
      |-> sfr_rdata == $past(sfr_wdata))
      else $error("high byte readback wrong");
endmodule
bind current_dac_update_control current_dac_update_control_sva i_sva (.*);

// >>> timer_model.sv
// timers standing beside the block: one overflow pulse on request
module timer_model (
   input wire logic clk,
   input wire logic fire,
   input wire logic [1:0] sel,
   output logic [3:0] timer_overflow
);
   always_ff @(posedge clk) begin
      timer_overflow <= fire ? (4'h1 << sel) : 4'h0;
   end
endmodule

// >>> current_dac_update_control_tb.sv
// testbench for the current dac update control block
module current_dac_update_control_tb
   import dac_update_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, srst = 1, sfr_write = 0, sfr_read = 0, pin = 0, fire = 0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;
   logic [1:0] tsel = 2'h0;
   logic [7:0] sfr_rdata;
   logic [3:0] tovf;
   logic [9:0] dac_latch;
   logic upd, en, pdd, pac, hit;
   logic [1:0] fss;
   full_scale_t fsm;
   int mismatches = 0, n_tests = 0;
   current_dac_update_control i_dut (.clk(clk), .srst(srst), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata),
      .sfr_hit(hit), .timer_overflow(tovf), .convert_start_pin(pin), .dac_latch(dac_latch),
      .dac_latch_update(upd), .dac_enable(en), .full_scale_select(fss), .full_scale_mode(fsm),
      .pin_digital_disable(pdd), .pin_analog_connect(pac));
   timer_model i_tmr (.clk(clk), .fire(fire), .sel(tsel), .timer_overflow(tovf));
   initial begin
      forever #20 clk = ~clk;
   end
   // ==========
   // shared tasks
   task wrap_up;
      $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // strobe stays up after the edge; the next access lowers or reuses it
   task wr(input logic [7:0] a, input logic [7:0] d);
      sfr_read = 0;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_write = 1;
      @(posedge clk);
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_write = 0;
      sfr_addr = a;
      sfr_read = 1;
      @(posedge clk);
      chk(sfr_rdata, exp);
      chk(hit, (a == 8'h96) || (a == 8'h97) || (a == 8'hB9));
      #1;
   endtask
   task wait_upd(input logic [9:0] exp);
      int i;
      i = 0;
      while (upd !== 1'b1 && i < 12) begin
         @(posedge clk); #1 i++;
      end
      if (i == 12) begin
         mismatches++;
         wrap_up;
      end else begin
         chk(dac_latch, exp);
      end
   endtask
   // ==========
   // scenarios
   task t_regs;
      rd(8'hB9, 8'h72);
      rd(8'h97, 8'h00);
      rd(8'h96, 8'h00);
      chk(fsm, SCALE_2P0);
      wr(8'hB9, 8'hFF);
      rd(8'hB9, 8'hF3);
      chk({pdd, pac, en}, 3'h7);
      wr(8'h96, 8'hFF);
      rd(8'h96, 8'hC0);
      wr(8'h97, 8'hA5);
      rd(8'h97, 8'hA5);
      rd(8'h55, 8'h00);
   endtask
   task t_write_mode;
      wr(8'hB9, 8'h71);
      chk(fsm, SCALE_1P0);
      wr(8'h96, 8'h40);
      chk(dac_latch, 10'h297);
      wr(8'h97, 8'h3C);
      chk({upd, dac_latch}, {1'b1, 10'h0F1});
   endtask
   task t_timer;
      for (int n = 0; n < 4; n++) begin
         wr(8'hB9, {1'b0, n[2:0], 4'h0});
         wr(8'h97, 8'h10 + n[7:0]);
         chk(dac_latch[9:2], (n == 0) ? 8'h3C : 8'h0F + n[7:0]);
         tsel = n[1:0]; fire = 1;
         @(posedge clk); #1 fire = 0;
         @(posedge clk); #1 chk(dac_latch, {8'h10 + n[7:0], 2'h1});
      end
      chk(fsm, SCALE_0P5);
      chk(fss, SCALE_HALF_MA);
   endtask
   task t_pin;
      wr(8'hB9, 8'h40); wr(8'h97, 8'h21); pin = 1; wait_upd(10'h085);
      wr(8'hB9, 8'h50); wr(8'h97, 8'h22); pin = 0; wait_upd(10'h089);
      wr(8'hB9, 8'h60); wr(8'h97, 8'h23); pin = 1; wait_upd(10'h08D);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      #1 srst = 0;
      t_regs;
      t_write_mode;
      t_timer;
      t_pin;
      wrap_up;
   end
endmodule
